//--- core/rvc_pkg.sv
/*
 * rvc_pkg: constants, register map and carrier types of the relay,
 * virtual link and comparator block.
 * assumes one 100 MHz clock and a plain strobed register port.
 */
package rvc_pkg;
    // --------------------------------------------------------------
    // sizes and timing
    // --------------------------------------------------------------
    localparam int NUM_RELAY      = 9;
    localparam int NUM_LINK       = 8;
    localparam int NUM_DIN        = 4;
    localparam int NUM_CMP        = 8;
    localparam int NUM_ANA_CMP    = 4;
    localparam int CLK_MHZ        = 100;
    localparam int TICK_MS        = 8;
    localparam int TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
    localparam int DLY_STEP_MS    = 100;
    localparam logic [6:0]  DLY_STEP_MS_W = 7'h64;
    localparam logic [25:0] TICK_MS_W     = 26'h0000008;
    // --------------------------------------------------------------
    // codes
    // --------------------------------------------------------------
    localparam logic [6:0]  FUNC_OFF      = 7'h00;
    localparam logic [6:0]  FUNC_TRIP     = 7'h01;
    localparam logic [6:0]  SRC_CA_BASE   = 7'h13;
    localparam logic [5:0]  DEST_OFF      = 6'h00;
    localparam logic [3:0]  VAL_CURRENT   = 4'h4;
    localparam logic        TYPE_HYST     = 1'b0;
    localparam logic        TYPE_WINDOW   = 1'b1;
    localparam logic        MODE_NO       = 1'b0;
    localparam logic [15:0] UPPER_RST     = 16'h012C;
    localparam logic [15:0] LOWER_RST     = 16'h00C8;
    // --------------------------------------------------------------
    // register map (word addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] A_RELAY  = 8'h00;
    localparam logic [7:0] A_LINK   = 8'h10;
    localparam logic [7:0] A_DIN    = 8'h18;
    localparam logic [7:0] A_CMP    = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h40;
    localparam int RELAY_MODE_BIT   = 8;
    localparam int LINK_DEST_LSB    = 8;
    localparam int CMP_TYPE_BIT     = 4;
    localparam int HI_HALF_LSB      = 16;
    // delay bits 18:16 ride in the select word of each comparator
    localparam int SET_EXT_LSB      = 16;
    localparam int RST_EXT_LSB      = 20;

    typedef struct packed {
        logic [15:0][15:0] val;
    } rvc_ana_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rvc_req_t;
endpackage : rvc_pkg

//--- core/rvc_top.sv
/*
 * rvc_top: relay function selection with contact mode, eight virtual
 * links, four analogue and four digital comparators with set and
 * reset delays, all refreshed on an 8 ms tick.
 * assumes function signals and analogue values come from same-clock
 * logic; digital inputs and board detect come from pins.
 */
`timescale 1ns/1ps
// Contract
// [R1] relay 2 takes a selectable function, off after reset
// [R2] relay 3 takes a selectable function, trip after reset
// [R3] three relays per detected option board, off after reset
// [R4] contact mode 0 drives the relay when its function is active
// [R5] contact mode 1 inverts the relay drive
// [R6] eight virtual links route one source to one destination, off default
// [R7] link destinations use the digital input function set
// [R8] link sources use the relay function signal set
// [R9] a function with several sources is the OR of them
// [R10] everything is re-evaluated on an 8 ms tick
// [R11] four analogue comparators against upper and lower thresholds
// [R12] four digital comparators on selected digital signals
// [R13] every comparator output has set delay, reset delay, readable timer
// [R14] hysteresis: above upper sets true high, inverted low
// [R15] hysteresis: below lower clears, between levels holds
// [R16] hysteresis with lower above upper latches once set
// [R17] window: inside band drives true high, inverted low
// [R18] window: outside band drives true low, inverted high
// [R19] value select codes 0 to 15, current (4) by default
// [R20] true and inverted comparator outputs are relay and link sources
// [R21] type select: hysteresis 0, window 1, hysteresis default
// [R22] delays from zero in tenth-second steps
// [R23] a value equal to a threshold has not crossed it
module rvc_top #(
    parameter int TICK_LEN = rvc_pkg::TICK_CYCLES
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire rvc_pkg::rvc_req_t     req,
    output logic [31:0]                rdata,
    input  wire logic [127:0]          func_sig,
    input  wire rvc_pkg::rvc_ana_t     ana,
    input  wire logic [3:0]            din_pin,
    input  wire logic [1:0]            board_pin,
    output logic [8:0]                 relay_out,
    output logic [63:0]                ctrl_func
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [22:0]       tick_cnt;
        logic              tick;
        logic [3:0]        din_m;
        logic [3:0]        din_s;
        logic [1:0]        brd_m;
        logic [1:0]        brd_s;
        logic [8:0][6:0]   relay_sel;
        logic [8:0]        relay_mode;
        logic [7:0][6:0]   link_src;
        logic [7:0][5:0]   link_dst;
        logic [3:0][5:0]   din_dst;
        logic [7:0][6:0]   cmp_sel;
        logic [7:0]        cmp_type;
        logic [7:0][15:0]  upper;
        logic [7:0][15:0]  lower;
        logic [7:0][18:0]  set_dly;
        logic [7:0][18:0]  rst_dly;
        logic [7:0][25:0]  tmr;
        logic [7:0]        raw;
        logic [7:0]        cmp_out;
        logic [8:0]        relay;
        logic [63:0]       ctrl;
        logic [31:0]       rdata;
    } rvc_state_t;

    rvc_state_t st;
    rvc_state_t next_st;

    function automatic logic sel_bit(input logic [127:0] v,
                                     input logic [6:0]   code);
        sel_bit = (code == rvc_pkg::FUNC_OFF) ? 1'b0 : v[code];
    endfunction : sel_bit

    // source vector with comparator outputs in their slots
    logic [127:0] src;
    always_comb
    begin
        src = func_sig;
        for (int k = 0; k < rvc_pkg::NUM_CMP; k++)
        begin
            src[rvc_pkg::SRC_CA_BASE + 7'(2 * k)]     = st.cmp_out[k]; // [R20]
            src[rvc_pkg::SRC_CA_BASE + 7'(2 * k + 1)] = ~st.cmp_out[k]; // [R20]
        end
    end

    // analogue value chosen for each analogue comparator
    logic [3:0][15:0] cmp_val;
    genvar g;
    generate
        for (g = 0; g < rvc_pkg::NUM_ANA_CMP; g++)
        begin : g_val
            assign cmp_val[g] = ana.val[st.cmp_sel[g][3:0]]; // [R19] [R11]
        end
    endgenerate

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        logic [2:0]  ci;
        logic [1:0]  cf;
        logic        above;
        logic        below;
        logic [15:0] cv;
        logic [25:0] elapsed;
        logic [25:0] target;
        logic [63:0] dst;
        next_st = st;
        ci = req.addr[4:2];
        cf = req.addr[1:0];
        above = 1'b0;
        below = 1'b0;
        cv = '0;
        elapsed = '0;
        target = '0;
        dst = '0;
        next_st.din_m = din_pin;
        next_st.din_s = st.din_m;
        next_st.brd_m = board_pin;
        next_st.brd_s = st.brd_m;
        // tick divider
        next_st.tick = 1'b0;
        next_st.tick_cnt = st.tick_cnt + 23'h1;
        if (st.tick_cnt == 23'(TICK_LEN - 1))
        begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1; // [R10]
        end
        // register writes
        if (req.wr)
        begin
            if (req.addr < 8'(rvc_pkg::NUM_RELAY))
            begin
                next_st.relay_sel[req.addr[3:0]] = req.wdata[6:0];
                next_st.relay_mode[req.addr[3:0]] =
                    req.wdata[rvc_pkg::RELAY_MODE_BIT];
            end
            else if (req.addr[7:3] == rvc_pkg::A_LINK[7:3])
            begin
                next_st.link_src[req.addr[2:0]] = req.wdata[6:0]; // [R8]
                next_st.link_dst[req.addr[2:0]] =
                    req.wdata[rvc_pkg::LINK_DEST_LSB +: 6]; // [R7]
            end
            else if (req.addr[7:2] == rvc_pkg::A_DIN[7:2])
                next_st.din_dst[req.addr[1:0]] = req.wdata[5:0];
            else if (req.addr[7:5] == rvc_pkg::A_CMP[7:5])
            begin
                case (cf)
                    2'h0:
                    begin
                        next_st.cmp_sel[ci] = req.wdata[6:0];
                        next_st.cmp_type[ci] =
                            req.wdata[rvc_pkg::CMP_TYPE_BIT]; // [R21]
                        next_st.set_dly[ci][18:16] =
                            req.wdata[rvc_pkg::SET_EXT_LSB +: 3]; // [R22]
                        next_st.rst_dly[ci][18:16] =
                            req.wdata[rvc_pkg::RST_EXT_LSB +: 3]; // [R22]
                    end
                    2'h1:
                    begin
                        next_st.upper[ci] = req.wdata[15:0];
                        next_st.lower[ci] =
                            req.wdata[rvc_pkg::HI_HALF_LSB +: 16];
                    end
                    2'h2:
                    begin
                        next_st.set_dly[ci][15:0] = req.wdata[15:0]; // [R22]
                        next_st.rst_dly[ci][15:0] =
                            req.wdata[rvc_pkg::HI_HALF_LSB +: 16]; // [R22]
                    end
                    default:
                        next_st.tmr[ci] = st.tmr[ci];
                endcase
            end
        end
        // register reads, data stand in the next cycle only
        next_st.rdata = '0;
        if (req.rd)
        begin
            if (req.addr < 8'(rvc_pkg::NUM_RELAY))
                next_st.rdata = {23'h0, st.relay_mode[req.addr[3:0]],
                                 1'b0, st.relay_sel[req.addr[3:0]]};
            else if (req.addr[7:3] == rvc_pkg::A_LINK[7:3])
                next_st.rdata = {18'h0, st.link_dst[req.addr[2:0]],
                                 1'b0, st.link_src[req.addr[2:0]]};
            else if (req.addr[7:2] == rvc_pkg::A_DIN[7:2])
                next_st.rdata = {26'h0, st.din_dst[req.addr[1:0]]};
            else if (req.addr[7:5] == rvc_pkg::A_CMP[7:5])
            begin
                case (cf)
                    2'h0: next_st.rdata = {9'h0, st.rst_dly[ci][18:16], 1'b0,
                                           st.set_dly[ci][18:16], 11'h0,
                                           st.cmp_type[ci], 4'h0} |
                                          {25'h0, st.cmp_sel[ci]};
                    2'h1: next_st.rdata = {st.lower[ci], st.upper[ci]};
                    2'h2: next_st.rdata = {st.rst_dly[ci][15:0],
                                           st.set_dly[ci][15:0]};
                    default: next_st.rdata = {6'h0, st.tmr[ci]}; // [R13]
                endcase
            end
            else if (req.addr == rvc_pkg::A_STATUS)
                next_st.rdata = {13'h0, st.brd_s, st.relay, st.cmp_out};
        end
        // periodic evaluation
        if (st.tick)
        begin
            for (int k = 0; k < rvc_pkg::NUM_CMP; k++)
            begin
                if (k < rvc_pkg::NUM_ANA_CMP)
                begin
                    // strict compares: equal is not crossed
                    cv = cmp_val[2'(k)];
                    above = cv > st.upper[k]; // [R23]
                    below = cv < st.lower[k]; // [R23]
                    if (st.cmp_type[k] == rvc_pkg::TYPE_WINDOW)
                        next_st.raw[k] = (cv > st.lower[k]) &&
                                         (cv < st.upper[k]); // [R17] [R18]
                    else if (above)
                        next_st.raw[k] = 1'b1; // [R14]
                    else if (below && !(st.lower[k] > st.upper[k]))
                        next_st.raw[k] = 1'b0; // [R15] [R16]
                end
                else
                    next_st.raw[k] = sel_bit(src, st.cmp_sel[k]); // [R12]
                // set and reset delay, timer counts in ms
                elapsed = st.tmr[k] + rvc_pkg::TICK_MS_W;
                target = 26'(st.raw[k] ? st.set_dly[k] : st.rst_dly[k])
                         * 26'(rvc_pkg::DLY_STEP_MS_W);
                if (st.raw[k] == st.cmp_out[k])
                    next_st.tmr[k] = '0;
                else if (elapsed >= target)
                begin
                    next_st.cmp_out[k] = st.raw[k]; // [R13]
                    next_st.tmr[k] = '0;
                end
                else
                    next_st.tmr[k] = elapsed; // [R13]
            end
            // relays 4..6 follow slot 1 detect, 7..9 slot 2
            for (int r = 0; r < rvc_pkg::NUM_RELAY; r++)
                next_st.relay[r] = (sel_bit(src, st.relay_sel[r]) ^
                                    st.relay_mode[r]) && // [R1] [R2] [R4] [R5]
                                   (r < 3 || st.brd_s[r / 6]); // [R3]
            for (int d = 0; d < rvc_pkg::NUM_DIN; d++)
                dst[st.din_dst[d]] = dst[st.din_dst[d]] | st.din_s[d]; // [R9]
            for (int l = 0; l < rvc_pkg::NUM_LINK; l++)
                dst[st.link_dst[l]] = dst[st.link_dst[l]] |
                                      sel_bit(src, st.link_src[l]); // [R6] [R9]
            dst[rvc_pkg::DEST_OFF] = 1'b0;
            next_st.ctrl = dst;
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.relay_sel[2] <= rvc_pkg::FUNC_TRIP; // [R2]
            for (int k = 0; k < rvc_pkg::NUM_ANA_CMP; k++)
            begin
                st.cmp_sel[k] <= {3'h0, rvc_pkg::VAL_CURRENT}; // [R19]
                st.upper[k] <= rvc_pkg::UPPER_RST;
                st.lower[k] <= rvc_pkg::LOWER_RST;
            end
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign relay_out = st.relay;
    assign ctrl_func = st.ctrl;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // relay 2 drive expected from its function and contact mode
    logic relay1_want;
    assign relay1_want = sel_bit(src, st.relay_sel[1]) ^ st.relay_mode[1];

    chk_tick_single: assert property ( // [R10]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick |=> !st.tick)
        else $error("tick lasted more than one cycle");
    chk_relay2_default: assert property ( // [R1]
        @(posedge core_clk)
        !rst_n |=> st.relay_sel[1] == rvc_pkg::FUNC_OFF)
        else $error("relay 2 select not off after reset");
    chk_relay3_default: assert property ( // [R2]
        @(posedge core_clk)
        !rst_n |=> st.relay_sel[2] == rvc_pkg::FUNC_TRIP)
        else $error("relay 3 select not trip after reset");
    chk_cmp_default: assert property ( // [R19] [R21]
        @(posedge core_clk)
        !rst_n |=> st.cmp_sel[0] == {3'h0, rvc_pkg::VAL_CURRENT} &&
                   st.cmp_type[0] == rvc_pkg::TYPE_HYST)
        else $error("comparator select or type not default after reset");
    chk_board_gate: assert property ( // [R3]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && !st.brd_s[1] |=> relay_out[8:6] == 3'h0)
        else $error("board relay driven without board");
    chk_board1_gate: assert property ( // [R3]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && !st.brd_s[0] |=> relay_out[5:3] == 3'h0)
        else $error("board 1 relay driven without board");
    chk_relay_mode: assert property ( // [R4] [R5]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick |=> relay_out[1] == $past(relay1_want))
        else $error("relay drive disagrees with function and mode");
    chk_hyst_set: assert property ( // [R14]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.cmp_type[0] == rvc_pkg::TYPE_HYST &&
        cmp_val[0] > st.upper[0] |=> st.raw[0])
        else $error("hysteresis did not set above upper");
    chk_hyst_clear: assert property ( // [R15]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.cmp_type[0] == rvc_pkg::TYPE_HYST &&
        cmp_val[0] < st.lower[0] && st.lower[0] <= st.upper[0] |=>
        !st.raw[0])
        else $error("hysteresis did not clear below lower");
    chk_hyst_latch: assert property ( // [R16]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.cmp_type[0] == rvc_pkg::TYPE_HYST &&
        st.lower[0] > st.upper[0] && st.raw[0] |=> st.raw[0])
        else $error("latched comparator released");
    chk_window_band: assert property ( // [R17] [R18]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.cmp_type[0] == rvc_pkg::TYPE_WINDOW |=>
        st.raw[0] == ($past(cmp_val[0]) > $past(st.lower[0]) &&
                      $past(cmp_val[0]) < $past(st.upper[0])))
        else $error("window output wrong");
    chk_link_route: assert property ( // [R6]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.link_dst[0] != rvc_pkg::DEST_OFF &&
        sel_bit(src, st.link_src[0]) |=> ctrl_func[$past(st.link_dst[0])])
        else $error("virtual link did not reach destination");
    chk_din_or: assert property ( // [R9]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.din_s[0] && st.din_dst[0] != rvc_pkg::DEST_OFF |=>
        ctrl_func[$past(st.din_dst[0])])
        else $error("digital input did not reach its function");
    chk_zero_delay: assert property ( // [R13]
        @(posedge core_clk) disable iff (!rst_n)
        st.tick && st.raw[2] && st.set_dly[2] == '0 |=> st.cmp_out[2])
        else $error("zero set delay did not pass output");
endmodule : rvc_top

//--- tb/rvc_far_side.sv
/*
 * rvc_far_side: model of the process side feeding the block: function
 * signals, analogue values, digital input pins and board detect.
 * assumes the bench sets the wanted levels; they reach the pins at the
 * next rising edge of core_clk.
 */
`timescale 1ns/1ps
module rvc_far_side (
    input  wire logic              core_clk,
    input  wire logic [127:0]      cmd_func,
    input  wire rvc_pkg::rvc_ana_t cmd_ana,
    input  wire logic [3:0]        cmd_din,
    input  wire logic [1:0]        cmd_board,
    output logic [127:0]           func_sig,
    output rvc_pkg::rvc_ana_t      ana,
    output logic [3:0]             din_pin,
    output logic [1:0]             board_pin
);
    // --------------------------------------------------------------
    // registered source levels
    // --------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        func_sig  <= cmd_func;
        ana       <= cmd_ana;
        din_pin   <= cmd_din;
        board_pin <= cmd_board;
    end
endmodule : rvc_far_side

//--- tb/rvc_top_bench.sv
/*
 * rvc_top_bench: register and pin level tests of relays, links and
 * comparators.
 * assumes rvc_top and rvc_far_side; tick shortened to 20 cycles.
 */
`timescale 1ns/1ps
module rvc_top_bench;
    localparam int TL = 20;
    logic              core_clk;
    logic              rst_n;
    rvc_pkg::rvc_req_t req;
    logic [31:0]       rdata;
    logic [31:0]       d;
    logic [127:0]      func;
    logic [127:0]      func_sig;
    rvc_pkg::rvc_ana_t ana_cmd;
    rvc_pkg::rvc_ana_t ana;
    logic [3:0]        din;
    logic [3:0]        din_pin;
    logic [1:0]        brd;
    logic [1:0]        board_pin;
    logic [8:0]        relay_out;
    logic [63:0]       ctrl_func;
    int                error_cnt;
    int                cmp_count;
    int                cyc;

    rvc_top #(.TICK_LEN(TL)) rvc_top_i (.core_clk(core_clk), .rst_n(rst_n),
        .req(req), .rdata(rdata), .func_sig(func_sig), .ana(ana),
        .din_pin(din_pin), .board_pin(board_pin), .relay_out(relay_out),
        .ctrl_func(ctrl_func));
    rvc_far_side rvc_far_side_i (.core_clk(core_clk), .cmd_func(func),
        .cmd_ana(ana_cmd), .cmd_din(din), .cmd_board(brd),
        .func_sig(func_sig), .ana(ana), .din_pin(din_pin),
        .board_pin(board_pin));

    // --------------------------------------------------------------
    // clock, timeout and shared tasks
    // --------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(logic [7:0] a, logic [31:0] wd);
        @(posedge core_clk);
        req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic rchk(logic [7:0] a, logic [31:0] exp, string what);
        rd(a);
        check(what, d, exp);
    endtask : rchk

    task automatic ticks(int n);
        repeat (n * TL) @(posedge core_clk);
        #1;
    endtask : ticks

    // relay 2 follows comparator 1 true, relay 1 its inverted output
    task automatic cmp_at(logic [15:0] v, logic e);
        ana_cmd.val[4] <= v;
        ticks(6);
        check("cmp1_pair", {30'h0, relay_out[1:0]}, {30'h0, e, ~e});
    endtask : cmp_at

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        func = '0;
        ana_cmd = '0;
        din = '0;
        brd = '0;
        error_cnt = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(8'h01, 32'h0, "relay2_sel");
        rchk(8'h02, {25'h0, rvc_pkg::FUNC_TRIP}, "relay3_sel");
        rchk(8'h03, 32'h0, "board_sel");
        rchk(8'h17, 32'h0, "link8");
        rchk(8'h20, 32'h4, "cmp1_sel");
        rchk(8'h21, 32'h00C8012C, "cmp1_levels");
        rchk(8'h44, 32'h0, "unmapped");
        wr(8'h2C, 32'h00550004);
        wr(8'h2E, 32'h7E3F7E3F);
        rchk(8'h2C, 32'h00550004, "cmp4_dly_ext");
        rchk(8'h2E, 32'h7E3F7E3F, "cmp4_dly_low");
        func[5] <= 1'b1;
        func[1] <= 1'b1;
        wr(8'h01, 32'h5);
        wr(8'h03, 32'h5);
        ticks(6);
        check("relay2", relay_out[1], 1'b1);
        check("relay3", relay_out[2], 1'b1);
        check("board_absent", relay_out[3], 1'b0);
        brd <= 2'h1;
        wr(8'h01, 32'h105);
        ticks(6);
        check("board1", relay_out[3], 1'b1);
        check("relay2_nc", relay_out[1], 1'b0);
        func[5] <= 1'b0;
        ticks(6);
        check("relay2_nc_idle", relay_out[1], 1'b1);
        check("board1_idle", relay_out[3], 1'b0);
        func[5] <= 1'b1;
        for (int k = 0; k < 8; k++)
            wr(8'h10 + 8'(k), (32'(k + 1) << 8) | 32'h5);
        ticks(6);
        check("links", ctrl_func[8:0], 32'h1FE);
        wr(8'h10, 32'h0905);
        wr(8'h18, 32'h9);
        for (int j = 0; j < 4; j++)
        begin
            func[5] <= j[0];
            din[0] <= j[1];
            ticks(6);
            check("or_func", ctrl_func[9], j[0] | j[1]);
        end
        wr(8'h30, 32'h5);
        ticks(6);
        rd(8'h40);
        check("dig_cmp", d[4], 1'b1);
        wr(8'h00, 32'h14);
        wr(8'h01, 32'h13);
        cmp_at(16'h015E, 1'b1);
        cmp_at(16'h00FA, 1'b1);
        cmp_at(16'h00C8, 1'b1);
        cmp_at(16'h00C7, 1'b0);
        cmp_at(16'h012C, 1'b0);
        cmp_at(16'h012D, 1'b1);
        wr(8'h21, 32'h01F40064);
        cmp_at(16'h0096, 1'b1);
        cmp_at(16'h0032, 1'b1);
        wr(8'h21, 32'h00C8012C);
        wr(8'h20, 32'h14);
        cmp_at(16'h00FA, 1'b1);
        cmp_at(16'h015E, 1'b0);
        cmp_at(16'h012C, 1'b0);
        cmp_at(16'h00C8, 1'b0);
        cmp_at(16'h0096, 1'b0);
        wr(8'h22, 32'h1);
        cmp_at(16'h00FA, 1'b0);
        rd(8'h23);
        check("cmp1_tmr", {31'h0, d[25:0] != '0}, 32'h1);
        check("cmp1_tmr_step", {29'h0, d[2:0]}, 32'h0);
        ticks(14);
        check("set_delay", relay_out[1], 1'b1);
        final_report();
    end
endmodule : rvc_top_bench
